// file: rtl/sbd_pkg.sv
package sbd_pkg;

  // Bus time slot and the long-low disable window.
  localparam int SLOT_NS = 25000;
  localparam int CLK_NS = 100;
  localparam int SLOT_CYCLES = SLOT_NS / CLK_NS;
  localparam int LOW_SLOTS = 9;

  // Register port map.
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STAT_VALID_BIT = 5;
  localparam int STAT_FAULT_BIT = 6;
  localparam int STAT_ENABLE_BIT = 7;

  // Control bits in arrival order: control_bit_0 arrives first.
  typedef struct packed {
    logic bridge_b_inhibit_n;
    logic bridge_b_direction;
    logic energize;
    logic bridge_a_direction;
    logic bridge_a_inhibit_n;
  } sbd_cmd_s;

  localparam sbd_cmd_s CMD_RESET = 5'h00;

  // What the frame receiver hands over.
  typedef struct packed {
    sbd_cmd_s control;
    logic push_ok;
    logic pull_sync;
  } sbd_rx_s;

  // One bridge: an output level and an active-low enable per pin.
  typedef struct packed {
    logic out_first;
    logic oe_first_n;
    logic out_second;
    logic oe_second_n;
  } sbd_bridge_s;

  localparam sbd_bridge_s BRIDGE_FLOAT = 4'h5;

endpackage

// file: rtl/sbd_low_watch.sv
`timescale 1ns/1ps
`default_nettype none

// Counts time slots while the bus sits dominant and pulses once when the
// run reaches the disable window.
module sbd_low_watch #(
  parameter int SLOT_CYC = sbd_pkg::SLOT_CYCLES,
  parameter int SLOTS = sbd_pkg::LOW_SLOTS
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic bus_level,
  output logic long_low
);
  import sbd_pkg::*;

  localparam int CW = $clog2(SLOT_CYC + 1);
  localparam int SW = $clog2(SLOTS + 1);
  localparam logic [CW-1:0] SLOT_LAST = CW'(SLOT_CYC - 1);
  localparam logic [SW-1:0] SLOT_LIMIT = SW'(SLOTS);

  logic [CW-1:0] cycle_count;
  logic [SW-1:0] slot_count;
  logic slot_tick;

  assign slot_tick = !bus_level && (cycle_count == SLOT_LAST);

  // A recessive bus restarts the run from zero.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      cycle_count <= '0;
    else if (bus_level || slot_tick)
      cycle_count <= '0;
    else
      cycle_count <= cycle_count + 1'b1;
  end

  // The slot count saturates so a bus held low gives one pulse only.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      slot_count <= '0;
    else if (bus_level)
      slot_count <= '0;
    else if (slot_tick && slot_count != SLOT_LIMIT)
      slot_count <= slot_count + 1'b1;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      long_low <= 1'b0;
    else
      long_low <= !bus_level && slot_tick && (slot_count == SLOT_LIMIT - 1'b1);
  end

  chk_long_low_cause: assert property (@(posedge mclk) disable iff (!reset_n)
    long_low |-> $past(slot_count) == SLOT_LIMIT - 1'b1 && !$past(bus_level))
    else $error("long-low pulse without nine dominant slots");

endmodule
`default_nettype wire

// file: rtl/sbd_bridge_decode.sv
`timescale 1ns/1ps
`default_nettype none

module sbd_bridge_decode (
  input wire logic mclk,
  input wire logic reset_n,
  input wire sbd_pkg::sbd_rx_s rx,
  input wire logic bus_level,
  input wire logic [sbd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic bridge_a_out_first,
  output logic bridge_a_oe_first_n,
  output logic bridge_a_out_second,
  output logic bridge_a_oe_second_n,
  output logic bridge_b_out_first,
  output logic bridge_b_oe_first_n,
  output logic bridge_b_out_second,
  output logic bridge_b_oe_second_n
);
  import sbd_pkg::*;

  // Maps one bridge's inhibit, direction and energize onto pin drives.
  function automatic sbd_bridge_s bridge_drive(input logic inhibit_n, input logic dir, input logic energize);
    sbd_bridge_s d;
    d = BRIDGE_FLOAT;
    if (!inhibit_n)
      d = BRIDGE_FLOAT;
    else if (energize)
    begin
      d.oe_first_n = 1'b0;
      d.oe_second_n = 1'b0;
      d.out_first = !dir;
      d.out_second = dir;
    end
    else if (!dir)
    begin
      d.out_first = 1'b1;
      d.oe_first_n = 1'b0;
    end
    else
    begin
      d.out_second = 1'b1;
      d.oe_second_n = 1'b0;
    end
    return d;
  endfunction

  sbd_cmd_s command;
  logic cmd_valid;
  logic bus_fault;
  logic sw_enable;
  logic pull_sync_q;
  logic latch_now;
  logic long_low;
  logic drive_on;
  sbd_bridge_s next_a;
  sbd_bridge_s next_b;
  sbd_bridge_s drive_a;
  sbd_bridge_s drive_b;

  // The bus level is taken as already resolved: dominant reads 0.
  sbd_low_watch #(
    .SLOT_CYC(SLOT_CYCLES),
    .SLOTS(LOW_SLOTS)
  ) u_low_watch (
    .mclk(mclk),
    .reset_n(reset_n),
    .bus_level(bus_level),
    .long_low(long_low)
  );

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      pull_sync_q <= 1'b0;
    else
      pull_sync_q <= rx.pull_sync;
  end

  // A pull-sync level without a validated push field changes nothing.
  assign latch_now = rx.pull_sync && !pull_sync_q && rx.push_ok;

  // Field order within the struct follows arrival order.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      command <= CMD_RESET;
    else if (latch_now)
      command <= rx.control;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      cmd_valid <= 1'b0;
    else if (latch_now)
      cmd_valid <= 1'b1;
  end

  // A new long-low run wins over a command latched in the same cycle, so a
  // shorted bus can never be cleared by a frame that raced it.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      bus_fault <= 1'b0;
    else if (long_low)
      bus_fault <= 1'b1;
    else if (latch_now)
      bus_fault <= 1'b0;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      sw_enable <= CTRL_RESET[CTRL_ENABLE_BIT];
    else if (reg_write && reg_addr == REG_CTRL)
      sw_enable <= reg_wdata[CTRL_ENABLE_BIT];
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= '0;
    else if (reg_read && reg_addr == REG_CTRL)
      reg_rdata <= {31'h0000_0000, sw_enable};
    else if (reg_read && reg_addr == REG_STATUS)
      reg_rdata <= {24'h00_0000, sw_enable, bus_fault, cmd_valid, command};
    else
      reg_rdata <= '0;
  end

  assign drive_on = cmd_valid && !bus_fault && sw_enable;

  always_comb
  begin
    next_a = BRIDGE_FLOAT;
    next_b = BRIDGE_FLOAT;
    if (drive_on)
    begin
      next_a = bridge_drive(command.bridge_a_inhibit_n, command.bridge_a_direction, command.energize);
      next_b = bridge_drive(command.bridge_b_inhibit_n, command.bridge_b_direction, command.energize);
    end
  end

  // The pins come straight from these flops, one cycle behind the latch.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      drive_a <= BRIDGE_FLOAT;
    else
      drive_a <= next_a;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      drive_b <= BRIDGE_FLOAT;
    else
      drive_b <= next_b;
  end

  assign bridge_a_out_first = drive_a.out_first;
  assign bridge_a_oe_first_n = drive_a.oe_first_n;
  assign bridge_a_out_second = drive_a.out_second;
  assign bridge_a_oe_second_n = drive_a.oe_second_n;
  assign bridge_b_out_first = drive_b.out_first;
  assign bridge_b_oe_first_n = drive_b.oe_first_n;
  assign bridge_b_out_second = drive_b.out_second;
  assign bridge_b_oe_second_n = drive_b.oe_second_n;

  chk_energized_polarity: assert property (@(posedge mclk) disable iff (!reset_n)
    drive_on && command.bridge_a_inhibit_n && command.energize
    |=> !bridge_a_oe_first_n && !bridge_a_oe_second_n
        && bridge_a_out_first == !$past(command.bridge_a_direction)
        && bridge_a_out_second == $past(command.bridge_a_direction))
    else $error("bridge a energized drive wrong");

  chk_dir_b_polarity: assert property (@(posedge mclk) disable iff (!reset_n)
    drive_on && command.bridge_b_inhibit_n && command.energize
    |=> bridge_b_out_second == $past(command.bridge_b_direction) && !bridge_b_oe_first_n)
    else $error("bridge b polarity does not follow its direction");

  chk_inhibit_float: assert property (@(posedge mclk) disable iff (!reset_n)
    (!command.bridge_a_inhibit_n || !command.bridge_b_inhibit_n)
    |=> ($past(command.bridge_a_inhibit_n) || (bridge_a_oe_first_n && bridge_a_oe_second_n))
        && ($past(command.bridge_b_inhibit_n) || (bridge_b_oe_first_n && bridge_b_oe_second_n)))
    else $error("inhibited bridge not floating");

  chk_unenergized_one: assert property (@(posedge mclk) disable iff (!reset_n)
    drive_on && command.bridge_a_inhibit_n && !command.energize
    |=> (bridge_a_oe_first_n != bridge_a_oe_second_n)
        && bridge_a_oe_first_n == $past(command.bridge_a_direction)
        && (bridge_a_out_first || bridge_a_out_second))
    else $error("bridge a unenergized drive wrong");

  chk_latch_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    (command != $past(command)) |-> $past(rx.pull_sync) && !$past(pull_sync_q) && $past(rx.push_ok))
    else $error("command changed without validated pull-sync rise");

  chk_fault_disable: assert property (@(posedge mclk) disable iff (!reset_n)
    long_low |=> bus_fault ##1 (bridge_a_oe_first_n && bridge_a_oe_second_n
                                && bridge_b_oe_first_n && bridge_b_oe_second_n))
    else $error("outputs not disabled after long dominant bus");

  chk_fault_resume: assert property (@(posedge mclk) disable iff (!reset_n)
    bus_fault && latch_now && !long_low |=> !bus_fault)
    else $error("fault not cleared by a new command");

  chk_float_before_cmd: assert property (@(posedge mclk) disable iff (!reset_n)
    !cmd_valid |=> bridge_a_oe_first_n && bridge_a_oe_second_n
                   && bridge_b_oe_first_n && bridge_b_oe_second_n)
    else $error("bridge driven before first command");

  // Covers the software off switch as well as the fault and reset gates.
  chk_off_floats: assert property (@(posedge mclk) disable iff (!reset_n)
    !drive_on |=> bridge_a_oe_first_n && bridge_a_oe_second_n
                  && bridge_b_oe_first_n && bridge_b_oe_second_n)
    else $error("bridge driven while the drive gate is off");

  // Bridge B has its own copies of the drive checks, since a swapped field in
  // the command struct would only show on one side.
  chk_energized_b_drive: assert property (@(posedge mclk) disable iff (!reset_n)
    drive_on && command.bridge_b_inhibit_n && command.energize
    |=> !bridge_b_oe_first_n && !bridge_b_oe_second_n
        && bridge_b_out_first == !$past(command.bridge_b_direction)
        && bridge_b_out_second == $past(command.bridge_b_direction))
    else $error("bridge b energized drive wrong");

  chk_unenergized_b_one: assert property (@(posedge mclk) disable iff (!reset_n)
    drive_on && command.bridge_b_inhibit_n && !command.energize
    |=> (bridge_b_oe_first_n != bridge_b_oe_second_n)
        && bridge_b_oe_first_n == $past(command.bridge_b_direction)
        && (bridge_b_out_first || bridge_b_out_second))
    else $error("bridge b unenergized drive wrong");

  chk_dir_a_polarity: assert property (@(posedge mclk) disable iff (!reset_n)
    drive_on && command.bridge_a_inhibit_n && command.energize
    |=> bridge_a_out_second == $past(command.bridge_a_direction) && !bridge_a_oe_second_n)
    else $error("bridge a polarity does not follow its direction");

  chk_b_coil_differs: assert property (@(posedge mclk) disable iff (!reset_n)
    drive_on && command.bridge_b_inhibit_n && command.energize
    |=> bridge_b_out_first != bridge_b_out_second)
    else $error("bridge b drives both ends of its coil alike");

  // A released pin is parked low so that the enable alone decides whether it drives.
  chk_float_low_level: assert property (@(posedge mclk) disable iff (!reset_n)
    (!bridge_a_oe_first_n || !bridge_a_out_first) && (!bridge_a_oe_second_n || !bridge_a_out_second)
    && (!bridge_b_oe_first_n || !bridge_b_out_first) && (!bridge_b_oe_second_n || !bridge_b_out_second))
    else $error("floating pin carries a high level");

  chk_command_capture: assert property (@(posedge mclk) disable iff (!reset_n)
    latch_now |=> command == $past(rx.control) && cmd_valid)
    else $error("latched command differs from received control bits");

  chk_pull_sync_track: assert property (@(posedge mclk) disable iff (!reset_n)
    pull_sync_q == $past(rx.pull_sync))
    else $error("pull-sync history does not follow the input");

  // Holding pull-sync high must not re-latch the data that follows it.
  chk_latch_once: assert property (@(posedge mclk) disable iff (!reset_n)
    rx.pull_sync && pull_sync_q |=> $stable(command))
    else $error("command latched without a pull-sync rise");

  chk_refused_frame: assert property (@(posedge mclk) disable iff (!reset_n)
    !rx.push_ok |=> $stable(command))
    else $error("command latched from an unvalidated frame");

  chk_fault_floats: assert property (@(posedge mclk) disable iff (!reset_n)
    bus_fault |=> bridge_a_oe_first_n && bridge_a_oe_second_n
                  && bridge_b_oe_first_n && bridge_b_oe_second_n)
    else $error("bridge driven while the bus fault stands");

  chk_fault_holds: assert property (@(posedge mclk) disable iff (!reset_n)
    bus_fault && !latch_now |=> bus_fault)
    else $error("bus fault cleared without a new command");

  chk_long_low_single: assert property (@(posedge mclk) disable iff (!reset_n)
    long_low |=> !long_low)
    else $error("long-low pulse lasted more than one cycle");

  chk_valid_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
    cmd_valid |=> cmd_valid)
    else $error("valid command flag dropped without reset");

  chk_idle_command: assert property (@(posedge mclk) disable iff (!reset_n)
    !cmd_valid |-> command == CMD_RESET)
    else $error("command changed before the first latch");

  // The watch reads the resolved level only: a recessive sample always
  // restarts the run, so a toggling bus never reaches the fault.
  chk_recessive_no_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
    bus_level |=> !long_low)
    else $error("long-low pulse after a recessive bus sample");

endmodule
`default_nettype wire

// file: dv/sbd_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host side: hands decoded frames to the block and owns the bus wire level.
module sbd_host_model (
  input wire logic mclk,
  output var sbd_pkg::sbd_rx_s rx,
  output var logic bus_level
);
  import sbd_pkg::*;

  // Eight half steps; the even-indexed entries alone form the full-step cycle.
  localparam sbd_cmd_s HALF [8] = '{5'b10101, 5'b00101, 5'b11101, 5'b11100,
    5'b11111, 5'b01111, 5'b10111, 5'b10110};

  initial
  begin
    rx = '0;
    bus_level = 1'b1;
  end

  function automatic sbd_cmd_s step(input int i);
    return HALF[i];
  endfunction

  // Data no longer stands once pull_sync has risen, so it is inverted.
  task automatic send(input sbd_cmd_s cmd, input logic ok, input int hold);
    @(posedge mclk);
    rx.control <= cmd;
    rx.push_ok <= ok;
    rx.pull_sync <= 1'b1;
    @(posedge mclk);
    rx.control <= ~cmd;
    repeat (hold - 1) @(posedge mclk);
    rx.pull_sync <= 1'b0;
    rx.push_ok <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic hold_low(input int n);
    @(posedge mclk);
    bus_level <= 1'b0;
    repeat (n) @(posedge mclk);
    bus_level <= 1'b1;
  endtask
endmodule

`default_nettype wire

// file: dv/sbd_bridge_decode_bench.sv
`timescale 1ns/1ps
`default_nettype none

module sbd_bridge_decode_bench;
  import sbd_pkg::*;
  logic mclk;
  logic reset_n;
  sbd_rx_s rx;
  logic bus_level;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [31:0] reg_rdata;
  wire logic [7:0] pins;
  int failures;
  int n_checks;

  sbd_host_model i_host (.mclk(mclk), .rx(rx), .bus_level(bus_level));

  sbd_bridge_decode i_dut (
    .mclk(mclk),
    .reset_n(reset_n),
    .rx(rx),
    .bus_level(bus_level),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .bridge_a_out_first(pins[7]),
    .bridge_a_oe_first_n(pins[6]),
    .bridge_a_out_second(pins[5]),
    .bridge_a_oe_second_n(pins[4]),
    .bridge_b_out_first(pins[3]),
    .bridge_b_oe_first_n(pins[2]),
    .bridge_b_out_second(pins[1]),
    .bridge_b_oe_second_n(pins[0])
  );

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic end_sim;
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_pins(input logic [7:0] exp);
    n_checks++;
    if (pins !== exp)
    begin
      failures++;
      $display("[ERR] pins expected %b seen %b", exp, pins);
    end
  endtask

  // Nibble is {out_first, oe_first_n, out_second, oe_second_n}.
  function automatic logic [3:0] bridge(input logic inh_n, input logic dir, input logic en);
    if (!inh_n)
      return 4'b0101;
    if (en)
      return dir ? 4'b0010 : 4'b1000;
    return dir ? 4'b0110 : 4'b1001;
  endfunction

  function automatic logic [7:0] exp_pins(input sbd_cmd_s c);
    return {bridge(c.bridge_a_inhibit_n, c.bridge_a_direction, c.energize),
      bridge(c.bridge_b_inhibit_n, c.bridge_b_direction, c.energize)};
  endfunction

  task automatic settle;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(negedge mclk);
    chk_word(what, exp, reg_rdata);
  endtask

  task automatic t_reset;
    settle();
    chk_pins(8'h55);
    reg_rd("ctrl", REG_CTRL, CTRL_RESET);
    reg_rd("status", REG_STATUS, 32'h0000_0080);
  endtask

  task automatic t_steps;
    sbd_cmd_s extra [4] = '{5'b11011, 5'b10001, 5'b00011, 5'b11000};
    for (int i = 0; i < 8; i++)
    begin
      i_host.send(i_host.step(i), 1'b1, 1);
      settle();
      chk_pins(exp_pins(i_host.step(i)));
    end
    for (int i = 0; i < 4; i++)
    begin
      i_host.send(extra[i], 1'b1, 1);
      settle();
      chk_pins(exp_pins(extra[i]));
    end
    reg_rd("status", REG_STATUS, {24'h00_0000, 3'b101, extra[3]});
  endtask

  task automatic t_refuse;
    i_host.send(5'b11111, 1'b1, 3);
    settle();
    chk_pins(exp_pins(5'b11111));
    i_host.send(5'b10101, 1'b0, 1);
    settle();
    chk_pins(exp_pins(5'b11111));
  endtask

  task automatic t_long_low;
    i_host.hold_low(2000);
    settle();
    chk_pins(exp_pins(5'b11111));
    i_host.hold_low(2260);
    settle();
    chk_pins(8'h55);
    reg_rd("status", REG_STATUS, 32'h0000_00FF);
    i_host.send(5'b10101, 1'b1, 1);
    settle();
    chk_pins(exp_pins(5'b10101));
    reg_rd("status", REG_STATUS, 32'h0000_00B5);
  endtask

  task automatic t_ctrl;
    reg_wr(REG_CTRL, 32'h0000_0000);
    settle();
    chk_pins(8'h55);
    reg_wr(4'hC, 32'h0000_0001);
    reg_rd("ctrl", REG_CTRL, 32'h0000_0000);
    reg_rd("unmapped", 4'h8, 32'h0000_0000);
    reg_wr(REG_CTRL, 32'h0000_0001);
    settle();
    chk_pins(exp_pins(5'b10101));
  endtask

  initial
  begin
    repeat (100000) @(posedge mclk);
    failures++;
    end_sim();
  end

  initial
  begin
    failures = 0;
    n_checks = 0;
    reset_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_steps();
    t_refuse();
    t_long_low();
    t_ctrl();
    end_sim();
  end
endmodule

`default_nettype wire
